// ### src/encoder_abz.sv
`timescale 1ns/1ps
`default_nettype none
`include "servo_io_regs.svh"
module encoder_abz (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // motor steps at configured resolution
   input  wire logic        motor_step,
   input  wire logic        motor_dir_cw,
   input  wire logic [15:0] pulses_per_rev_setting,
   // encoder phases
   output logic             enc_a,
   output logic             enc_b,
   output logic             enc_z
);
   logic [15:0] eff_res;
   logic [15:0] res;
   logic [16:0] acc_q, acc_d, acc_sum;
   logic [1:0]  ph_q, ph_d;
   logic [15:0] pos_q, pos_d;
   logic        z_q, z_d;
   logic        emit;

   assign res     = (pulses_per_rev_setting == 16'h0000) ? 16'h0001
                                                         : pulses_per_rev_setting;
   assign eff_res = (res < `ENC_MAX_PPR) ? res : `ENC_MAX_PPR;
   assign acc_sum = acc_q + {1'b0, eff_res};
   assign emit    = motor_step && (acc_sum >= {1'b0, res});

   always_comb begin
      acc_d = acc_q;
      ph_d  = ph_q;
      pos_d = pos_q;
      if (motor_step) begin
         acc_d = emit ? acc_sum - {1'b0, res} : acc_sum;
      end
      if (emit) begin
         if (motor_dir_cw) begin
            ph_d  = ph_q + 2'h1;
            pos_d = (pos_q + 16'h0001 >= eff_res) ? 16'h0000 : pos_q + 16'h0001;
         end else begin
            ph_d  = ph_q - 2'h1;
            pos_d = (pos_q == 16'h0000) ? eff_res - 16'h0001 : pos_q - 16'h0001;
         end
      end
      z_d = (pos_d == 16'h0000);
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         acc_q <= 17'h00000;
         ph_q  <= 2'h0;
         pos_q <= 16'h0000;
         z_q   <= 1'b1;
      end else begin
         acc_q <= acc_d;
         ph_q  <= ph_d;
         pos_q <= pos_d;
         z_q   <= z_d;
      end
   end

   // gray sequence 00,01,11,10 on b,a
   assign enc_a = ph_q[0] ^ ph_q[1];
   assign enc_b = ph_q[1];
   assign enc_z = z_q;

   quad_one_step_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $changed(ph_q) |-> $past(emit) && !($changed(enc_a) && $changed(enc_b)))
      else $error("quadrature moved without emit or both phases flipped");
   res_capped_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      eff_res <= `ENC_MAX_PPR)
      else $error("encoder resolution above cap");
endmodule // encoder_abz
`default_nettype wire

// ### src/input_filter.sv
`timescale 1ns/1ps
`default_nettype none
module input_filter (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   // timing
   input  wire logic       ms_tick,
   input  wire logic [5:0] input_debounce_time,
   // inputs
   input  wire logic [5:0] in_raw,
   output logic      [5:0] in_filt
);
   logic [5:0] cnt_q [6];
   logic [5:0] cnt_d [6];
   logic [5:0] filt_q;
   logic [5:0] filt_d;
   logic [5:0] limit;

   assign limit   = (input_debounce_time == 6'h00) ? 6'h01 : input_debounce_time;
   assign in_filt = filt_q;

   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_bit
         always_comb begin
            cnt_d[g]  = cnt_q[g];
            filt_d[g] = filt_q[g];
            if (in_raw[g] == filt_q[g]) begin
               cnt_d[g] = 6'h00;
            end else if (ms_tick) begin
               if (cnt_q[g] + 6'h01 >= limit) begin
                  filt_d[g] = in_raw[g];
                  cnt_d[g]  = 6'h00;
               end else begin
                  cnt_d[g] = cnt_q[g] + 6'h01;
               end
            end
         end
         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               cnt_q[g]  <= 6'h00;
               filt_q[g] <= 1'b0;
            end else begin
               cnt_q[g]  <= cnt_d[g];
               filt_q[g] <= filt_d[g];
            end
         end
      end
   endgenerate

   filt_needs_ticks_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $changed(filt_q) |-> $past(ms_tick))
      else $error("filtered input changed without a ms tick");
endmodule // input_filter
`default_nettype wire

// ### src/servo_io_function_logic.sv
`timescale 1ns/1ps
`default_nettype none
`include "servo_io_regs.svh"
module servo_io_function_logic #(
   parameter int MS_CYCLES = `MS_TICK_CYCLES
) (
   // clock and reset
   input  wire logic                       clk_sys,
   input  wire logic                       rst_b,
   // raw inputs 1..6 in bits 0..5
   input  wire logic [5:0]                 in_raw,
   // input settings
   input  wire logic [5:0]                 input_debounce_time,
   input  wire logic [1:0]                 input1_role_select,
   input  wire logic [1:0]                 input2_role_select,
   input  wire logic [14:0]                manual_move_speed,
   input  wire logic [6:0]                 inching_distance,
   input  wire logic [11:0]                inch_to_jog_shift_time,
   // output settings
   input  wire logic                       output_mode_select,
   input  wire logic [3:0]                 out1_function_select,
   input  wire logic [3:0]                 out2_function_select,
   input  wire logic [3:0]                 out3_function_select,
   input  wire logic [14:0]                move_speed_threshold,
   input  wire logic signed [31:0]         zone_lower_bound,
   input  wire logic signed [31:0]         zone_upper_bound,
   input  wire logic [15:0]                in_position_window,
   input  wire logic [15:0]                pulses_per_rev_setting,
   // motion core state
   input  wire logic signed [31:0]         present_position,
   input  wire logic signed [31:0]         target_position,
   input  wire logic [14:0]                present_speed,
   input  wire logic                       motor_step,
   input  wire logic                       motor_dir_cw,
   input  wire logic                       motion_start,
   input  wire logic                       motion_done,
   input  wire logic                       motion_busy,
   input  wire logic                       push_active,
   input  wire logic                       origin_set,
   input  wire logic                       alarm_event,
   input  wire logic                       status_warning,
   input  wire logic signed [31:0]         entry_zone_lower,
   input  wire logic signed [31:0]         entry_zone_upper,
   input  wire logic [2:0]                 general_out,
   // host commands
   input  wire logic                       exec_cmd_req,
   input  wire logic                       teach_cmd_req,
   input  wire logic [4:0]                 teach_index,
   output logic                            exec_cmd_accept,
   output logic                            exec_cmd_refused,
   output servo_io_pkg::teach_wr_t         teach_wr,
   // motion requests
   output servo_io_pkg::manual_cmd_t       manual_cmd,
   output logic                            manual_active,
   output logic                            soft_limit_enable,
   output logic                            limit_stop_req,
   output logic                            ccw_block,
   output logic                            cw_block,
   output logic                            origin_sensor,
   // servo and status
   output logic                            servo_on,
   output logic                            alarm_clear,
   output logic [15:0]                     status_word_reply,
   output logic [7:0]                      warn_code,
   // output pins 1..4 in bits 0..3
   output logic [3:0]                      out_pins
);
   logic [5:0]  in_filt, filt_q;
   logic        ms_tick;
   logic [14:0] tick_cnt_q, tick_cnt_d;

   // common millisecond tick
   always_comb begin
      tick_cnt_d = tick_cnt_q + 15'h0001;
      if (tick_cnt_q == 15'(MS_CYCLES - 1)) begin
         tick_cnt_d = 15'h0000;
      end
   end
   assign ms_tick = (tick_cnt_q == 15'(MS_CYCLES - 1));

   input_filter u_filter (
      .clk_sys             (clk_sys),
      .rst_b               (rst_b),
      .ms_tick             (ms_tick),
      .input_debounce_time (input_debounce_time),
      .in_raw              (in_raw),
      .in_filt             (in_filt)
   );

   logic [5:0] rise, fall;
   assign rise = in_filt & ~filt_q;
   assign fall = ~in_filt & filt_q;

   // sensor roles
   logic ccw_lim, cw_lim, lim_any_q;
   assign ccw_lim = (in_filt[0] && input1_role_select == `ROLE_CCW_LIMIT)
                 || (in_filt[1] && input2_role_select == `ROLE_CCW_LIMIT);
   assign cw_lim  = (in_filt[0] && input1_role_select == `ROLE_CW_LIMIT)
                 || (in_filt[1] && input2_role_select == `ROLE_CW_LIMIT);
   assign origin_sensor = in_filt[0] && input1_role_select == `ROLE_ORIGIN;
   assign ccw_block = ccw_lim;
   assign cw_block  = cw_lim;

   // servo, alarm and warning state
   logic servo_q, servo_d, alarm_q, alarm_d, warn_q, warn_d, clr_d, stop_d;
   always_comb begin
      servo_d = servo_q;
      alarm_d = alarm_q;
      warn_d  = warn_q;
      clr_d   = 1'b0;
      stop_d  = (ccw_lim || cw_lim) && !lim_any_q;
      if (rise[2]) begin
         servo_d = 1'b1;
         clr_d   = 1'b1;
         alarm_d = 1'b0;
         warn_d  = 1'b0;
      end else if (fall[2]) begin
         servo_d = 1'b0;
      end
      if (alarm_event) begin
         alarm_d = 1'b1;
         servo_d = 1'b0;
      end
      if (stop_d) begin
         warn_d = 1'b1;
      end
   end

   // manual mode sequencer
   servo_io_pkg::manual_state_t st_q, st_d;
   logic [11:0] shift_q, shift_d;
   logic        dir_q, dir_d, inch_d;
   logic        dir_on, go_ccw, go_cw;
   assign manual_active     = in_filt[3];
   assign soft_limit_enable = !in_filt[3];
   assign go_ccw = rise[4] && !ccw_lim;
   assign go_cw  = rise[5] && !cw_lim;
   assign dir_on = dir_q ? (in_filt[5] && !cw_lim) : (in_filt[4] && !ccw_lim);

   always_comb begin
      st_d    = st_q;
      shift_d = shift_q;
      dir_d   = dir_q;
      inch_d  = 1'b0;
      case (st_q)
         servo_io_pkg::MAN_IDLE: begin
            if (manual_active && servo_q && (go_ccw || go_cw)) begin
               dir_d   = go_cw && !go_ccw;
               shift_d = 12'h000;
               if (inch_to_jog_shift_time == 12'h000) begin
                  st_d = servo_io_pkg::MAN_JOG;
               end else begin
                  inch_d = 1'b1;
                  st_d   = servo_io_pkg::MAN_INCH;
               end
            end
         end
         servo_io_pkg::MAN_INCH: begin
            if (!dir_on || !manual_active) begin
               st_d = servo_io_pkg::MAN_IDLE;
            end else if (ms_tick) begin
               shift_d = shift_q + 12'h001;
               if (shift_q + 12'h001 >= inch_to_jog_shift_time) begin
                  st_d = servo_io_pkg::MAN_JOG;
               end
            end
         end
         servo_io_pkg::MAN_JOG: begin
            if (!dir_on || !manual_active || !servo_q) begin
               st_d = servo_io_pkg::MAN_IDLE;
            end
         end
         default: st_d = servo_io_pkg::MAN_IDLE;
      endcase
   end

   // command gating and teaching
   servo_io_pkg::teach_wr_t teach_d;
   logic acc_d, ref_d;
   always_comb begin
      acc_d = exec_cmd_req && !manual_active;
      ref_d = exec_cmd_req && manual_active;
      teach_d.wr_en    = teach_cmd_req && manual_active;
      teach_d.index    = teach_index;
      teach_d.position = present_position;
   end

   // output functions
   logic signed [32:0] pos_err;
   logic [32:0] abs_err;
   logic in_pos, zone_hit, ezone_hit, move_hit;
   logic end_q, end_d, ezv_q, ezv_d;
   logic signed [31:0] ezl_q, ezh_q, ezl_d, ezh_d;
   assign pos_err   = 33'(present_position) - 33'(target_position);
   assign abs_err   = pos_err[32] ? 33'(-pos_err) : 33'(pos_err);
   assign in_pos    = abs_err <= {17'h00000, in_position_window};
   assign zone_hit  = present_position >= zone_lower_bound
                   && present_position <= zone_upper_bound;
   assign ezone_hit = ezv_q && present_position >= ezl_q
                   && present_position <= ezh_q;
   assign move_hit  = present_speed > move_speed_threshold;

   always_comb begin
      end_d = end_q;
      ezv_d = ezv_q;
      ezl_d = ezl_q;
      ezh_d = ezh_q;
      if (motion_start) begin
         end_d = 1'b0;
         ezv_d = 1'b1;
         ezl_d = entry_zone_lower;
         ezh_d = entry_zone_upper;
      end
      if (motion_done) begin
         end_d = 1'b1;
      end
   end

   logic [10:0] fn_vec;
   logic [2:0]  user_out;
   logic        enc_a, enc_b, enc_z;
   logic [3:0]  pins_d;
   logic [3:0]  fsel [3];
   assign fsel[0] = out1_function_select;
   assign fsel[1] = out2_function_select;
   assign fsel[2] = out3_function_select;

   // shared status functions; the general bit is filled per output
   always_comb begin
      fn_vec = 11'h000;
      fn_vec[`FN_IN_POSITION] = in_pos;
      fn_vec[`FN_WARNING]     = warn_q || status_warning;
      fn_vec[`FN_ENTRY_ZONE]  = ezone_hit;
      fn_vec[`FN_ZONE]        = zone_hit;
      fn_vec[`FN_MOVE]        = move_hit;
      fn_vec[`FN_BUSY]        = motion_busy;
      fn_vec[`FN_END]         = end_q;
      fn_vec[`FN_SERVO_ON]    = servo_q;
      fn_vec[`FN_PUSH]        = push_active;
      fn_vec[`FN_ORIGIN_SET]  = origin_set;
   end

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_out
         logic [10:0] fn_g;
         always_comb begin
            fn_g              = fn_vec;
            fn_g[`FN_GENERAL] = general_out[g];
         end
         assign user_out[g] = (fsel[g] <= `FN_ORIGIN_SET) ? fn_g[fsel[g]]
                                                          : 1'b0;
      end
   endgenerate

   encoder_abz u_enc (
      .clk_sys                (clk_sys),
      .rst_b                  (rst_b),
      .motor_step             (motor_step),
      .motor_dir_cw           (motor_dir_cw),
      .pulses_per_rev_setting (pulses_per_rev_setting),
      .enc_a                  (enc_a),
      .enc_b                  (enc_b),
      .enc_z                  (enc_z)
   );

   always_comb begin
      pins_d[3] = alarm_q;
      if (output_mode_select == `OUT_MODE_ABZ) begin
         pins_d[2:0] = {enc_z, enc_b, enc_a};
      end else begin
         pins_d[2:0] = user_out;
      end
   end

   // registered stage
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tick_cnt_q        <= 15'h0000;
         filt_q            <= 6'h00;
         lim_any_q         <= 1'b0;
         servo_q           <= 1'b0;
         alarm_q           <= 1'b0;
         warn_q            <= 1'b0;
         alarm_clear       <= 1'b0;
         limit_stop_req    <= 1'b0;
         st_q              <= servo_io_pkg::MAN_IDLE;
         shift_q           <= 12'h000;
         dir_q             <= 1'b0;
         manual_cmd        <= '0;
         exec_cmd_accept   <= 1'b0;
         exec_cmd_refused  <= 1'b0;
         teach_wr          <= '0;
         end_q             <= 1'b0;
         ezv_q             <= 1'b0;
         ezl_q             <= 32'sh0;
         ezh_q             <= 32'sh0;
         out_pins          <= 4'h0;
         status_word_reply <= `STAT_SERVO_OFF;
         warn_code         <= 8'h00;
      end else begin
         tick_cnt_q        <= tick_cnt_d;
         filt_q            <= in_filt;
         lim_any_q         <= ccw_lim || cw_lim;
         servo_q           <= servo_d;
         alarm_q           <= alarm_d;
         warn_q            <= warn_d;
         alarm_clear       <= clr_d;
         limit_stop_req    <= stop_d;
         st_q              <= st_d;
         shift_q           <= shift_d;
         dir_q             <= dir_d;
         manual_cmd.start  <= inch_d;
         manual_cmd.jog    <= (st_d == servo_io_pkg::MAN_JOG);
         manual_cmd.dir_cw <= dir_d;
         manual_cmd.distance <= inching_distance;
         manual_cmd.speed  <= manual_move_speed;
         exec_cmd_accept   <= acc_d;
         exec_cmd_refused  <= ref_d;
         teach_wr          <= teach_d;
         end_q             <= end_d;
         ezv_q             <= ezv_d;
         ezl_q             <= ezl_d;
         ezh_q             <= ezh_d;
         out_pins          <= pins_d;
         status_word_reply <= (servo_d ? (in_pos ? `STAT_IN_POSITION : 16'h0000)
                                       : `STAT_SERVO_OFF)
                            | (warn_d ? `STAT_OP_WARNING : 16'h0000);
         warn_code         <= warn_d ? `WARN_LIMIT : 8'h00;
      end
   end
   assign servo_on = servo_q;

   // checks
   sequence press_s;
      st_q == servo_io_pkg::MAN_IDLE && manual_active && servo_q && go_ccw;
   endsequence
   manual_inch_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (press_s and (inch_to_jog_shift_time != 12'h000)) |=> manual_cmd.start
      && manual_cmd.distance == $past(inching_distance))
      else $error("inching move not issued");
   zero_shift_jog_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (press_s and (inch_to_jog_shift_time == 12'h000)) |=> manual_cmd.jog
      && !manual_cmd.start)
      else $error("zero shift time did not jog at once");
   jog_release_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      st_q == servo_io_pkg::MAN_JOG && !dir_on |=> !manual_cmd.jog)
      else $error("jog continued after release");
   exec_refuse_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      exec_cmd_req && manual_active |=> exec_cmd_refused && !exec_cmd_accept)
      else $error("execution accepted in manual mode");
   servo_toggle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      rise[2] && !alarm_event |=> servo_on && alarm_clear && !alarm_q
      && status_word_reply[4] == 1'b0)
      else $error("servo-on edge not honoured");
   alarm_off_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      alarm_event |=> !servo_on ##1 out_pins[3])
      else $error("alarm did not drop servo and raise output 4");
   limit_warn_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (ccw_lim || cw_lim) && !lim_any_q && !rise[2] |=> limit_stop_req
      && warn_code == `WARN_LIMIT && status_word_reply[8])
      else $error("limit stop not reported");
   teach_store_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      teach_cmd_req && manual_active |=> teach_wr.wr_en
      && teach_wr.position == $past(present_position))
      else $error("teaching did not capture position");
endmodule // servo_io_function_logic
`default_nettype wire

// ### src/servo_io_pkg.sv
package servo_io_pkg;
   typedef enum logic [1:0] {MAN_IDLE, MAN_INCH, MAN_JOG} manual_state_t;
   typedef struct packed {
      logic        start;
      logic        jog;
      logic        dir_cw;
      logic [6:0]  distance;
      logic [14:0] speed;
   } manual_cmd_t;
   typedef struct packed {
      logic        wr_en;
      logic [4:0]  index;
      logic [31:0] position;
   } teach_wr_t;
endpackage

// ### src/servo_io_regs.svh
// Summary of operation
// - input 1 is origin(1), ccw limit(2) or cw limit(3); input 2 ccw/cw limit
// - every input is filtered 1 to 50 ms; a change must hold over that many consecutive ms ticks to be seen
// - input 4 on selects manual mode, refusing execution but not teaching
// - manual mode: input 5 moves ccw, input 6 moves cw
// - direction input start moves inching distance at manual speed
// - input held past shift time turns inching into jog; early release inches only
// - jog keeps rotating while direction input stays on, stops on release
// - zero shift time skips inching and jogs at once
// - teaching stores present position into the named motion entry
// - software travel limits are off during manual mode
// - input 3 on clears alarm, servo on, status 8 while in position; off servo off, status 16
// - limit on: status 256, decelerating stop, warning code 4
// - after limit stop only motion away from that sensor is allowed
// - output 4 always shows alarm; any alarm turns the servo off
// - output mode 0: outputs 1 to 3 carry A, B and once-per-turn Z
// - encoder resolution follows setting below 3000 ppr, else held at 3000
// - output mode 1: outputs 1 to 3 each pick one of functions 0 to 10
// - in-position while present position is within window of target
// - END on completion; pause gives in-position but no END
// - entry zone on inside entry bounds, from execution to next positioning
// - zone on inside parameter bounds for every kind of operation
// - MOVE on while speed exceeds threshold
`ifndef SERVO_IO_REGS_SVH
`define SERVO_IO_REGS_SVH
`define CLK_PERIOD_NS     40
`define MS_PERIOD_NS      1000000
`define MS_TICK_CYCLES    (`MS_PERIOD_NS / `CLK_PERIOD_NS)
`define ROLE_ORIGIN       2'h1
`define ROLE_CCW_LIMIT    2'h2
`define ROLE_CW_LIMIT     2'h3
`define STAT_IN_POSITION  16'h0008
`define STAT_SERVO_OFF    16'h0010
`define STAT_OP_WARNING   16'h0100
`define WARN_LIMIT        8'h04
`define ENC_MAX_PPR       16'h0BB8
`define OUT_MODE_ABZ      1'h0
`define FN_GENERAL        4'h0
`define FN_IN_POSITION    4'h1
`define FN_WARNING        4'h2
`define FN_ENTRY_ZONE     4'h3
`define FN_ZONE           4'h4
`define FN_MOVE           4'h5
`define FN_BUSY           4'h6
`define FN_END            4'h7
`define FN_SERVO_ON       4'h8
`define FN_PUSH           4'h9
`define FN_ORIGIN_SET     4'hA
`endif

// ### verification/io_partner.sv
`timescale 1ns/1ps
`default_nettype none
module io_partner (
   // clock
   input  wire logic       clk_sys,
   // contact levels commanded by the bench
   input  wire logic [5:0] sw_on,
   output logic      [5:0] in_raw
);
   initial in_raw = 6'h00;
   // contacts change just after an edge
   always @(posedge clk_sys) begin
      in_raw <= sw_on;
   end
endmodule // io_partner
`default_nettype wire

// ### verification/servo_io_function_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
module servo_io_function_logic_tb;
   logic clk_sys = 0, rst_b = 0, output_mode_select = 0, motor_step = 0;
   logic motor_dir_cw = 0, motion_start = 0, motion_done = 0, push_active = 0;
   logic motion_busy = 1, origin_set = 1, alarm_event = 0, status_warning = 0;
   logic exec_cmd_req = 0, teach_cmd_req = 0;
   logic [5:0] input_debounce_time = 6'h02, sw_on = 6'h00;
   wire logic [5:0] in_raw;
   logic [1:0] input1_role_select = 2'h2, input2_role_select = 2'h3;
   logic [14:0] manual_move_speed = 15'h0032, move_speed_threshold = 15'h000A;
   logic [14:0] present_speed = 15'h0014;
   logic [6:0] inching_distance = 7'h64;
   logic [11:0] inch_to_jog_shift_time = 12'h003;
   logic [3:0] out1_function_select = 4'h0, out2_function_select = 4'h0;
   logic [3:0] out3_function_select = 4'h0;
   logic signed [31:0] zone_lower_bound = 32'h32, zone_upper_bound = 32'h96;
   logic signed [31:0] present_position = 32'h64, target_position = 32'h66;
   logic signed [31:0] entry_zone_lower = 32'h0, entry_zone_upper = 32'h0;
   logic [15:0] in_position_window = 16'h0005;
   logic [15:0] pulses_per_rev_setting = 16'h03E8;
   logic [2:0] general_out = 3'h6;
   logic [4:0] teach_index = 5'h13;
   logic exec_cmd_accept, exec_cmd_refused, manual_active, soft_limit_enable;
   logic limit_stop_req, ccw_block, cw_block, origin_sensor, servo_on;
   logic alarm_clear;
   servo_io_pkg::teach_wr_t teach_wr;
   servo_io_pkg::manual_cmd_t manual_cmd;
   logic [15:0] status_word_reply;
   logic [7:0] warn_code;
   logic [3:0] out_pins;
   int n_fail = 0, num_checks = 0, i;
   // each row: output function code, then the level it should give
   logic [4:0] rows [11] = '{5'h00, 5'h03, 5'h04, 5'h06, 5'h09, 5'h0B,
                             5'h0D, 5'h0E, 5'h10, 5'h12, 5'h15};
   io_partner u_io_partner (.clk_sys, .sw_on, .in_raw);
   servo_io_function_logic #(.MS_CYCLES(4)) u_servo_io_function_logic (.*);
   always #20 clk_sys = ~clk_sys;
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n = 1);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic tally_and_finish;
      if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   function automatic logic pick(input int k);
      case (k)
         0: return servo_on;
         1: return manual_cmd.start;
         2: return manual_cmd.jog;
         default: return limit_stop_req;
      endcase
   endfunction
   task automatic wait_for(input int k, input logic v);
      int t;
      for (t = 0; t < 100 && pick(k) !== v; t++) step();
      if (t == 100) begin
         n_fail++;
         $display("Error at %0t: wait ran out", $time);
         tally_and_finish();
      end
   endtask
   initial begin
      step(5);
      chk(status_word_reply, 16'h0010);
      rst_b = 1;
      step(2);
      chk(out_pins[2], 1'h1);
      motor_dir_cw = 1;
      motor_step = 1;
      step();
      motor_step = 0;
      step();
      chk(out_pins[2:0], 3'h1);
      output_mode_select = 1;
      for (i = 0; i < 11; i++) begin
         out1_function_select = rows[i][4:1];
         step(2);
         chk(out_pins[0], rows[i][0]);
      end
      sw_on[2] = 1;
      step(3);
      sw_on[2] = 0;
      step(12);
      chk(servo_on, 1'h0);
      sw_on[2] = 1;
      wait_for(0, 1);
      step();
      chk(status_word_reply, 16'h0008);
      exec_cmd_req = 1;
      step();
      exec_cmd_req = 0;
      chk(exec_cmd_accept, 1'h1);
      sw_on[3] = 1;
      step(12);
      chk(soft_limit_enable, 1'h0);
      exec_cmd_req = 1;
      step();
      exec_cmd_req = 0;
      chk(exec_cmd_refused, 1'h1);
      teach_cmd_req = 1;
      step();
      teach_cmd_req = 0;
      chk(teach_wr, {1'h1, 5'h13, 32'h64});
      sw_on[4] = 1;
      wait_for(1, 1);
      chk(manual_cmd, {3'h4, 7'h64, 15'h0032});
      wait_for(2, 1);
      sw_on[4] = 0;
      step(4);
      chk(manual_cmd.jog, 1'h1);
      wait_for(2, 0);
      inch_to_jog_shift_time = 12'h000;
      sw_on[5] = 1;
      wait_for(2, 1);
      chk(manual_cmd.dir_cw, 1'h1);
      sw_on[5:3] = 3'h0;
      step(12);
      sw_on[0] = 1;
      wait_for(3, 1);
      step(2);
      chk(warn_code, 8'h04);
      chk(status_word_reply[8], 1'h1);
      chk(ccw_block, 1'h1);
      alarm_event = 1;
      step();
      alarm_event = 0;
      step(2);
      chk(out_pins[3], 1'h1);
      chk(servo_on, 1'h0);
      tally_and_finish();
   end
endmodule // servo_io_function_logic_tb
`default_nettype wire
